// ### core/tcbl_latch.sv
// How it works
// - In capture mode a byte read holds both bytes until the other is read.
// - A write to channel_status_control releases the capture read latch.
// - In compare or PWM mode the first byte write of a pair is buffered, not made active.
// - Once both bytes are written the pair moves into the value at once.
// - In write modes a channel_status_control write drops a half pair.
// - The write pair completes in either byte order.
module tcbl_latch (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire tcbl_pkg::tcbl_mode_t mode,
    input wire tcbl_pkg::tcbl_req_t req,
    input wire logic capture_strobe,
    input wire logic [15:0] capture_value,
    output logic [7:0] rdata,
    output logic [15:0] channel_value,
    output logic value_loaded,
    output logic read_latched
);

    // ==========================================================
    // Decode
    // ==========================================================

    // The PWM mode shares the compare path because both drive outputs
    // from the same channel value.
    wire logic is_capture;
    wire logic is_write_mode;
    wire logic any_read;
    wire logic sc_write;
    assign is_capture = (mode == tcbl_pkg::TCBL_MODE_CAPTURE);
    assign is_write_mode = (mode == tcbl_pkg::TCBL_MODE_COMPARE) ||
                           (mode == tcbl_pkg::TCBL_MODE_PWM);
    assign any_read = req.rd_high || req.rd_low;
    assign sc_write = req.wr_status_control;

    // ==========================================================
    // Channel value and capture read latch
    // ==========================================================

    // State registers and their next values.
    logic [15:0] value_reg;
    logic [15:0] value_next;
    logic [15:0] hold_reg;
    logic latched_reg;
    logic latched_next;
    logic first_high_reg;
    logic first_high_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic loaded_reg;

    // Reads come from the hold copy while a pair is open, so both
    // halves software sees belong to the same captured word.
    wire logic [15:0] read_src;
    wire logic opposite_read;
    wire logic open_latch;
    assign read_src = latched_reg ? hold_reg : value_reg;
    // Apart from a status write, the pair ends only on the byte opposite the one that opened it.
    assign opposite_read = latched_reg &&
        ((first_high_reg && req.rd_low) ||
         (!first_high_reg && req.rd_high));
    assign open_latch = is_capture && any_read && !latched_reg;

    // The latch state; a status write wins over a read in the same
    // cycle so software always gets fresh data afterwards.
    always_comb begin
        latched_next = latched_reg;
        first_high_next = first_high_reg;
        if (sc_write) begin
            latched_next = 1'b0;
        end else if (open_latch) begin
            latched_next = 1'b1;
            first_high_next = req.rd_high;
        end else if (opposite_read) begin
            latched_next = 1'b0;
        end
    end

    // Read data; reading the high byte first when unlatched still takes
    // it from the live value, which the hold copy matches that cycle.
    always_comb begin
        rdata_next = rdata_reg;
        if (req.rd_high) begin
            rdata_next = read_src[tcbl_pkg::TCBL_HIGH_LSB +: 8];
        end else if (req.rd_low) begin
            rdata_next = read_src[tcbl_pkg::TCBL_LOW_LSB +: 8];
        end
    end

    // ==========================================================
    // Write buffer
    // ==========================================================

    // Byte strobes count only in the write modes.
    wire logic [7:0] buf_high;
    wire logic [7:0] buf_low;
    wire logic full_high;
    wire logic full_low;
    wire logic ld_high;
    wire logic ld_low;
    wire logic pair_done;
    wire logic buf_clr;
    assign ld_high = is_write_mode && req.wr_high;
    assign ld_low = is_write_mode && req.wr_low;
    // Done once each half is held or arriving now, in any order.
    assign pair_done = (full_high || ld_high) && (full_low || ld_low) &&
                       (ld_high || ld_low);
    assign buf_clr = pair_done || (is_write_mode && sc_write) ||
                     !is_write_mode;

    // A completing byte goes straight to the value and is not buffered;
    // holding it would leave a stale half behind after the commit.
    wire logic load_high;
    wire logic load_low;
    assign load_high = ld_high && !pair_done;
    assign load_low = ld_low && !pair_done;

    tcbl_byte_reg u_high (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .clr(buf_clr),
        .load(load_high),
        .d(req.wdata),
        .q(buf_high),
        .full(full_high)
    );

    tcbl_byte_reg u_low (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .clr(buf_clr),
        .load(load_low),
        .d(req.wdata),
        .q(buf_low),
        .full(full_low)
    );

    // ==========================================================
    // Commit
    // ==========================================================

    // The completing byte comes from the bus, the other from its buffer.
    wire logic [15:0] pair_word;
    assign pair_word = {ld_high ? req.wdata : buf_high,
                        ld_low ? req.wdata : buf_low};

    // The channel value takes a whole word from either source.
    always_comb begin
        value_next = value_reg;
        if (pair_done) begin
            value_next = pair_word;
        end else if (is_capture && capture_strobe) begin
            value_next = capture_value;
        end
    end

    // ==========================================================
    // Registers
    // ==========================================================

    // Active channel value; it changes only as a whole word, which is
    // what keeps a compare from ever seeing half an update.
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            value_reg <= tcbl_pkg::TCBL_VALUE_RST;
        end else begin
            value_reg <= value_next;
        end
    end

    // The hold copy is taken only when a read opens the latch, so a
    // capture that lands mid-pair cannot tear the word software sees.
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            hold_reg <= tcbl_pkg::TCBL_VALUE_RST;
        end else if (open_latch) begin
            hold_reg <= value_reg;
        end
    end

    // Latch state and the byte that opened the pair; the opener decides
    // which read closes it.
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            latched_reg <= 1'b0;
            first_high_reg <= 1'b0;
        end else begin
            latched_reg <= latched_next;
            first_high_reg <= first_high_next;
        end
    end

    // Read data stands until the next read.
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            rdata_reg <= tcbl_pkg::TCBL_BYTE_RST;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // One-cycle pulse after a pair is committed.
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            loaded_reg <= 1'b0;
        end else begin
            loaded_reg <= pair_done;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================

    // Every output comes straight from a register, so the bus side
    // never sees decode glitches.
    assign rdata = rdata_reg;
    assign channel_value = value_reg;
    assign value_loaded = loaded_reg;
    assign read_latched = latched_reg;

endmodule

// ### core/tcbl_pkg.sv
package tcbl_pkg;

    // ==========================================================
    // Channel modes and bus request carrier
    // ==========================================================

    // Channel operating mode as seen by the byte latch.
    typedef enum logic [1:0] {
        TCBL_MODE_CAPTURE = 2'h0,
        TCBL_MODE_COMPARE = 2'h1,
        TCBL_MODE_PWM = 2'h2,
        TCBL_MODE_OFF = 2'h3
    } tcbl_mode_t;

    // One CPU bus access, valid for one cycle when any strobe is set.
    typedef struct packed {
        logic rd_high;
        logic rd_low;
        logic wr_high;
        logic wr_low;
        logic wr_status_control;
        logic [7:0] wdata;
    } tcbl_req_t;

    // Reset values.
    localparam logic [15:0] TCBL_VALUE_RST = 16'h0000;
    localparam logic [7:0] TCBL_BYTE_RST = 8'h00;

    // Byte positions inside the 16-bit channel value.
    localparam int TCBL_HIGH_LSB = 8;
    localparam int TCBL_LOW_LSB = 0;

endpackage

// ### core/tcbl_byte_reg.sv
module tcbl_byte_reg (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic clr,
    input wire logic load,
    input wire logic [7:0] d,
    output logic [7:0] q,
    output logic full
);

    // ==========================================================
    // One held byte with a half-done flag
    // ==========================================================

    // A clear in the same cycle as a load gives way to the load, so a
    // byte written alongside a restart is not lost.
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            q <= tcbl_pkg::TCBL_BYTE_RST;
            full <= 1'b0;
        end else if (load) begin
            q <= d;
            full <= 1'b1;
        end else if (clr) begin
            full <= 1'b0;
        end
    end

endmodule

// ### tb/tcbl_latch_monitor.sv
module tcbl_latch_chk (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire tcbl_pkg::tcbl_mode_t mode,
    input wire tcbl_pkg::tcbl_req_t req,
    input wire logic [15:0] channel_value,
    input wire logic value_loaded,
    input wire logic read_latched
);
    timeunit 1ns;
    timeprecision 1ns;
    // ====================================================
    // Mode decode
    // ====================================================
    // A status write beats a read, so it is kept out of the read mode.
    wire logic wm = mode inside {tcbl_pkg::TCBL_MODE_COMPARE,
        tcbl_pkg::TCBL_MODE_PWM};
    wire logic cm = mode == tcbl_pkg::TCBL_MODE_CAPTURE &&
        !req.wr_status_control;
    wire logic rd = req.rd_high || req.rd_low;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    // ====================================================
    // Properties
    // ====================================================
    sequence s_clr;
        req.wr_status_control && wm;
    endsequence
    property p_lat;
        !read_latched && cm && rd |=> read_latched;
    endproperty
    property p_cap;
        !read_latched && cm && req.rd_high ##1 cm && req.rd_low
            |=> !read_latched;
    endproperty
    property p_rel;
        req.wr_status_control |=> !read_latched;
    endproperty
    property p_hold;
        wm && $past(wm) && !value_loaded |-> $stable(channel_value);
    endproperty
    property p_pair;
        s_clr ##1 req.wr_low && wm ##1 req.wr_high && wm |=>
            value_loaded && channel_value[15:8] == $past(req.wdata);
    endproperty
    property p_swap;
        s_clr ##1 req.wr_high && wm ##1 req.wr_low && wm |=>
            value_loaded && channel_value[7:0] == $past(req.wdata);
    endproperty
    property p_abort;
        req.wr_high && wm ##1 s_clr ##1 req.wr_low |=> !value_loaded;
    endproperty
    property p_done;
        value_loaded && wm && req.wr_high |=> !value_loaded;
    endproperty
    a_lat: assert property (p_lat) else $error("no latch");
    a_cap: assert property (p_cap) else $error("no release");
    a_rel: assert property (p_rel) else $error("latch kept");
    a_hold: assert property (p_hold) else $error("early load");
    a_pair: assert property (p_pair) else $error("no load");
    a_swap: assert property (p_swap) else $error("no load");
    a_abort: assert property (p_abort) else $error("stale");
    a_done: assert property (p_done) else $error("reload");
endmodule
bind tcbl_latch tcbl_latch_chk u_tcbl_latch_chk (.ref_clk(ref_clk),
    .nrst(nrst), .mode(mode), .req(req), .channel_value(channel_value),
    .value_loaded(value_loaded), .read_latched(read_latched));

// ### tb/tcbl_cpu_model.sv
module tcbl_cpu_model (
    input wire logic ref_clk,
    output tcbl_pkg::tcbl_req_t req
);
    timeunit 1ns;
    timeprecision 1ns;
    initial req = '0;
    // One strobe per access, set at the falling edge, held a full cycle.
    task automatic op(input logic [4:0] s, input logic [7:0] d);
        @(negedge ref_clk);
        req = {s, d};
    endtask
    // Idle shows inverted data so a stale byte can never pass as valid.
    task automatic idle();
        @(negedge ref_clk);
        req = {5'h00, ~req.wdata};
    endtask
endmodule

// ### tb/timer_channel_byte_latch_tb_top.sv
module timer_channel_byte_latch_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [4:0] RH = 5'h10, RL = 5'h08, WH = 5'h04;
    localparam logic [4:0] WL = 5'h02, SC = 5'h01;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    tcbl_pkg::tcbl_mode_t mode = tcbl_pkg::TCBL_MODE_CAPTURE;
    tcbl_pkg::tcbl_req_t req;
    logic capture_strobe = 1'b0;
    logic [15:0] capture_value = 16'h0000;
    logic [7:0] rdata;
    logic [15:0] channel_value;
    logic value_loaded;
    logic read_latched;
    int num_errors = 0;
    int n_compared = 0;
    always #20 ref_clk = ~ref_clk;
    tcbl_cpu_model u_tcbl_cpu_model (.ref_clk(ref_clk), .req(req));
    tcbl_latch u_tcbl_latch (.ref_clk(ref_clk), .nrst(nrst), .mode(mode),
        .req(req), .capture_strobe(capture_strobe),
        .capture_value(capture_value), .rdata(rdata),
        .channel_value(channel_value), .value_loaded(value_loaded),
        .read_latched(read_latched));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cap(input logic [15:0] v);
        @(negedge ref_clk);
        capture_value = v;
        capture_strobe = 1'b1;
        @(negedge ref_clk);
        capture_strobe = 1'b0;
    endtask
    task automatic rd(input logic [4:0] s, input logic [7:0] exp);
        u_tcbl_cpu_model.op(s, 8'h00);
        u_tcbl_cpu_model.idle();
        chk({8'h00, rdata}, {8'h00, exp});
    endtask
    // Snapshot survives a new capture until the opposite byte is read.
    task automatic t_cap();
        cap(16'h1234);
        rd(RH, 8'h12);
        cap(16'h5678);
        rd(RL, 8'h34);
        rd(RL, 8'h78);
    endtask
    // A status write drops a held pair, so the next read is fresh.
    task automatic t_rel();
        rd(RH, 8'h56);
        rd(RL, 8'h78);
        cap(16'h9abc);
        u_tcbl_cpu_model.op(SC, 8'h00);
        u_tcbl_cpu_model.idle();
        chk_bit(read_latched, 1'b0);
        rd(RH, 8'h9a);
        chk_bit(read_latched, 1'b1);
        cap(16'hdef0);
        rd(RH, 8'h9a);
        rd(RL, 8'hbc);
        chk_bit(read_latched, 1'b0);
        cap(16'h1357);
        u_tcbl_cpu_model.op(RH, 8'h00);
        rd(RL, 8'h57);
        chk_bit(read_latched, 1'b0);
    endtask
    // Nothing moves before the pair is whole; a status write restarts it.
    task automatic t_wr();
        mode = tcbl_pkg::TCBL_MODE_COMPARE;
        u_tcbl_cpu_model.op(SC, 8'h00);
        u_tcbl_cpu_model.op(WL, 8'h11);
        u_tcbl_cpu_model.op(WH, 8'h22);
        u_tcbl_cpu_model.op(WH, 8'h33);
        chk(channel_value, 16'h2211);
        chk_bit(value_loaded, 1'b1);
        u_tcbl_cpu_model.op(SC, 8'h00);
        chk(channel_value, 16'h2211);
        u_tcbl_cpu_model.op(WL, 8'h44);
        u_tcbl_cpu_model.op(WH, 8'h55);
        chk(channel_value, 16'h2211);
        chk_bit(value_loaded, 1'b0);
        u_tcbl_cpu_model.idle();
        chk(channel_value, 16'h5544);
    endtask
    task automatic t_swap();
        mode = tcbl_pkg::TCBL_MODE_PWM;
        u_tcbl_cpu_model.op(SC, 8'h00);
        u_tcbl_cpu_model.op(WH, 8'h66);
        u_tcbl_cpu_model.op(WL, 8'h77);
        u_tcbl_cpu_model.idle();
        chk(channel_value, 16'h6677);
        chk_bit(value_loaded, 1'b1);
        u_tcbl_cpu_model.op(WH, 8'h88);
        u_tcbl_cpu_model.idle();
        chk(channel_value, 16'h6677);
    endtask
    // Writes outside compare and PWM are dropped and empty the buffer.
    task automatic t_off();
        mode = tcbl_pkg::TCBL_MODE_OFF;
        u_tcbl_cpu_model.op(WL, 8'h99);
        u_tcbl_cpu_model.idle();
        mode = tcbl_pkg::TCBL_MODE_COMPARE;
        u_tcbl_cpu_model.op(WL, 8'haa);
        u_tcbl_cpu_model.idle();
        chk(channel_value, 16'h6677);
        chk_bit(value_loaded, 1'b0);
    endtask
    task automatic print_verdict();
        $display("compared %0d errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Hold reset for twelve cycles, then run every scenario in turn.
    initial begin
        repeat (12) @(negedge ref_clk);
        nrst = 1'b1;
        t_cap();
        t_rel();
        t_wr();
        t_swap();
        t_off();
        print_verdict();
    end
endmodule
